// ---- hdl/nfb_regs.vh ----
// timing and pin constants for the parallel nor flash bus controller
// assumes a 100 MHz controller clock; included by the design files
`ifndef NFB_REGS_VH
`define NFB_REGS_VH

`define NFB_CLK_PERIOD_NS   10
`define NFB_ADDR_W          18
`define NFB_DATA_W          16
// access times in ns, figures of the slower speed grade by default
`define NFB_TACC_NS         90
`define NFB_TCE_NS          90
`define NFB_TOE_NS          35
`define NFB_TWP_NS          35
`define NFB_TWPH_NS         30
`define NFB_TAS_NS          0
`define NFB_TDF_NS          30
`define NFB_SLEEP_EXTRA_NS  30
// least times round up to whole cycles
`define NFB_CYC(ns)         (((ns) + `NFB_CLK_PERIOD_NS - 1) / `NFB_CLK_PERIOD_NS)
`define NFB_TACC_CYC        `NFB_CYC(`NFB_TACC_NS)
`define NFB_TCE_CYC         `NFB_CYC(`NFB_TCE_NS)
`define NFB_TOE_CYC         `NFB_CYC(`NFB_TOE_NS)
`define NFB_TWP_CYC         `NFB_CYC(`NFB_TWP_NS)
`define NFB_TWPH_CYC        `NFB_CYC(`NFB_TWPH_NS)
`define NFB_TDF_CYC         `NFB_CYC(`NFB_TDF_NS)
`define NFB_SLEEP_CYC       `NFB_CYC(`NFB_TACC_NS + `NFB_SLEEP_EXTRA_NS)
// one spare setup edge plus two synchroniser stages on read data
`define NFB_RD_EXTRA_CYC    3
`define NFB_CNT_W           8
// operation codes on the request port
`define NFB_OP_READ         2'b00
`define NFB_OP_WRITE        2'b01

`endif

// ---- hdl/nfb_sync.v ----
// two-flip-flop synchroniser for the data bus coming back from the flash
// assumes REF_CLK domain; the pins are asynchronous to it
`timescale 1ns/1ns
module nfb_sync #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule

// ---- hdl/nfb_ctrl.v ----
// host-side bus controller for an asynchronous parallel nor flash
// assumes one request port on REF_CLK; the flash sees only the strobes, address and data
`timescale 1ns/1ns
`include "nfb_regs.vh"

module nfb_ctrl (
	input  wire                     REF_CLK,
	input  wire                     RESET,
	input  wire                     REQ_VALID,
	output wire                     REQ_READY,
	input  wire [1:0]               REQ_OP,
	input  wire [`NFB_ADDR_W-1:0]   REQ_ADDR,
	input  wire [`NFB_DATA_W-1:0]   REQ_WDATA,
	output reg                      RSP_VALID,
	output reg  [`NFB_DATA_W-1:0]   RSP_RDATA,
	output wire                     IDLE_ASLEEP,
	output reg  [`NFB_ADDR_W-1:0]   WORD_ADDRESS_IN,
	input  wire [`NFB_DATA_W-1:0]   DATA_BUS_I,
	output reg  [`NFB_DATA_W-1:0]   DATA_BUS_O,
	output reg                      DATA_BUS_OE,
	output reg                      CE_N,
	output reg                      OE_N,
	output reg                      WE_N
);

	////////////////////////////////////////////////////////////////////////////
	localparam [2:0] ST_IDLE   = 3'd0;
	localparam [2:0] ST_RD     = 3'd1;
	localparam [2:0] ST_WSETUP = 3'd2;
	localparam [2:0] ST_WPULSE = 3'd3;
	localparam [2:0] ST_WHOLD  = 3'd4;
	localparam [2:0] ST_TURN   = 3'd5;

	localparam integer          TACC_I  = `NFB_TACC_CYC;
	localparam integer          TCE_I   = `NFB_TCE_CYC;
	localparam integer          TWP_I   = `NFB_TWP_CYC;
	localparam integer          TWPH_I  = `NFB_TWPH_CYC;
	localparam integer          TDF_I   = `NFB_TDF_CYC;
	localparam integer          SLEEP_I = `NFB_SLEEP_CYC;
	localparam integer          SYNC_I  = `NFB_RD_EXTRA_CYC;
	// counts cut to the counter width on purpose; all fit in eight bits
	localparam [`NFB_CNT_W-1:0] TACC_C  = TACC_I[`NFB_CNT_W-1:0];
	localparam [`NFB_CNT_W-1:0] TCE_C   = TCE_I[`NFB_CNT_W-1:0];
	localparam [`NFB_CNT_W-1:0] TWP_C   = TWP_I[`NFB_CNT_W-1:0];
	localparam [`NFB_CNT_W-1:0] TWPH_C  = TWPH_I[`NFB_CNT_W-1:0];
	localparam [`NFB_CNT_W-1:0] TDF_C   = TDF_I[`NFB_CNT_W-1:0];
	localparam [`NFB_CNT_W-1:0] SLEEP_C = SLEEP_I[`NFB_CNT_W-1:0];
	// a sample taken right at the access time has no setup margin,
	// so one spare edge comes before the two synchroniser stages
	localparam [`NFB_CNT_W-1:0] SYNC_C  = SYNC_I[`NFB_CNT_W-1:0];

	reg  [2:0]             state_ff, nxt_state;
	reg  [`NFB_CNT_W-1:0]  cnt_ff, nxt_cnt;
	reg  [`NFB_CNT_W-1:0]  stable_ff, nxt_stable;
	reg                    selected_ff, nxt_selected;
	wire [`NFB_DATA_W-1:0] data_sync;

	nfb_sync #(.W(`NFB_DATA_W)) u_sync (
		.clk (REF_CLK),
		.rst (RESET),
		.d   (DATA_BUS_I),
		.q   (data_sync)
	);

	function [`NFB_CNT_W-1:0] rd_wait;
		input sel;
		begin
			// from standby the select access time governs, else address access
			rd_wait = ((sel ? TACC_C : TCE_C) > TACC_C ? TCE_C : TACC_C) + SYNC_C;
			if (sel)
				rd_wait = TACC_C + SYNC_C;
		end
	endfunction

	assign REQ_READY   = (state_ff == ST_IDLE);
	// the flash sleeps on its own; we only report when that is expected
	assign IDLE_ASLEEP = (stable_ff >= SLEEP_C);

	////////////////////////////////////////////////////////////////////////////
	always @* begin
		nxt_state    = state_ff;
		nxt_cnt      = cnt_ff;
		nxt_selected = selected_ff;
		case (state_ff)
			ST_IDLE: begin
				if (REQ_VALID) begin
					if (REQ_OP == `NFB_OP_WRITE) begin
						nxt_state = ST_WSETUP;
						nxt_cnt   = 8'h01;
					end else begin
						nxt_state = ST_RD;
						nxt_cnt   = rd_wait(selected_ff);
					end
				end
			end
			ST_RD: begin
				if (cnt_ff <= 8'h01) begin
					nxt_state = ST_TURN;
					nxt_cnt   = TDF_C;
					nxt_selected = 1'b1;
				end else
					nxt_cnt = cnt_ff - 8'h01;
			end
			ST_WSETUP: begin
				nxt_state = ST_WPULSE;
				nxt_cnt   = TWP_C;
			end
			ST_WPULSE: begin
				if (cnt_ff <= 8'h01) begin
					nxt_state = ST_WHOLD;
					nxt_cnt   = TWPH_C;
				end else
					nxt_cnt = cnt_ff - 8'h01;
			end
			ST_WHOLD: begin
				if (cnt_ff <= 8'h01) begin
					nxt_state    = ST_IDLE;
					nxt_selected = 1'b0;
				end else
					nxt_cnt = cnt_ff - 8'h01;
			end
			ST_TURN: begin
				// output float time before the bus may turn around
				if (cnt_ff <= 8'h01) begin
					nxt_state    = ST_IDLE;
					nxt_selected = 1'b0;
				end else
					nxt_cnt = cnt_ff - 8'h01;
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_cnt   = 8'h00;
			end
		endcase
	end

	always @* begin
		nxt_stable = stable_ff;
		if (state_ff == ST_IDLE && REQ_VALID)
			nxt_stable = 8'h00;
		else if (stable_ff != 8'hFF)
			nxt_stable = stable_ff + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	always @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			state_ff        <= ST_IDLE;
			cnt_ff          <= 8'h00;
			stable_ff       <= 8'h00;
			selected_ff     <= 1'b0;
			CE_N            <= 1'b1;
			OE_N            <= 1'b1;
			WE_N            <= 1'b1;
			DATA_BUS_OE     <= 1'b0;
			DATA_BUS_O      <= 16'h0000;
			WORD_ADDRESS_IN <= 18'h0_0000;
			RSP_VALID       <= 1'b0;
			RSP_RDATA       <= 16'h0000;
		end else begin
			state_ff    <= nxt_state;
			cnt_ff      <= nxt_cnt;
			stable_ff   <= nxt_stable;
			selected_ff <= nxt_selected;
			RSP_VALID   <= 1'b0;
			// address held after the cycle so the flash may sleep on it
			if (state_ff == ST_IDLE && REQ_VALID)
				WORD_ADDRESS_IN <= REQ_ADDR;
			if (state_ff == ST_IDLE && REQ_VALID && REQ_OP != `NFB_OP_WRITE) begin
				CE_N        <= 1'b0;
				OE_N        <= 1'b0;
				WE_N        <= 1'b1;
				DATA_BUS_OE <= 1'b0;
			end
			if (state_ff == ST_IDLE && REQ_VALID && REQ_OP == `NFB_OP_WRITE) begin
				// address settles with select before write-enable falls
				CE_N        <= 1'b0;
				OE_N        <= 1'b1;
				WE_N        <= 1'b1;
				DATA_BUS_O  <= REQ_WDATA;
				DATA_BUS_OE <= 1'b1;
			end
			if (state_ff == ST_WSETUP)
				WE_N <= 1'b0;
			if (state_ff == ST_WPULSE && cnt_ff <= 8'h01)
				WE_N <= 1'b1;
			if (state_ff == ST_WHOLD && cnt_ff <= 8'h01) begin
				CE_N        <= 1'b1;
				DATA_BUS_OE <= 1'b0;
			end
			if (state_ff == ST_RD && cnt_ff <= 8'h01) begin
				// array, id or status word alike: the flash picks the source
				RSP_VALID <= 1'b1;
				RSP_RDATA <= data_sync;
				OE_N      <= 1'b1;
			end
			if (state_ff == ST_TURN && cnt_ff <= 8'h01)
				CE_N <= 1'b1;
		end
	end

endmodule

// ---- dv/nfb_ctrl_props.sv ----
// port checker for the nor flash bus controller
// assumes bind into nfb_ctrl; one clock domain
`timescale 1ns/1ns
`include "nfb_regs.vh"
module nfb_ctrl_props (
	input wire                   REF_CLK,
	input wire                   RESET,
	input wire                   REQ_READY,
	input wire                   RSP_VALID,
	input wire                   IDLE_ASLEEP,
	input wire [`NFB_ADDR_W-1:0] WORD_ADDRESS_IN,
	input wire                   DATA_BUS_OE,
	input wire                   CE_N,
	input wire                   OE_N,
	input wire                   WE_N
);
default clocking @(posedge REF_CLK); endclocking
default disable iff (RESET);
chk_read_strobes:
	assert property (!OE_N |-> !CE_N && WE_N) else $error("read strobes wrong");
chk_write_strobes:
	assert property (!WE_N |-> !CE_N && OE_N && DATA_BUS_OE) else $error("write strobes wrong");
chk_read_no_drive:
	assert property (!OE_N |-> !DATA_BUS_OE) else $error("bus driven during read");
chk_read_access:
	assert property (RSP_VALID |-> $past(OE_N, 9) == 1'b0) else $error("read data too early");
chk_we_width:
	assert property ($fell(WE_N) |=> !WE_N [*3] ##1 WE_N) else $error("write pulse width");
chk_ready_idle:
	assert property (REQ_READY |-> CE_N && OE_N && WE_N) else $error("idle not deselected");
chk_rsp_pulse:
	assert property (RSP_VALID |=> !RSP_VALID) else $error("response not a pulse");
chk_addr_steady:
	assert property (!CE_N && !$past(CE_N) |-> $stable(WORD_ADDRESS_IN))
	else $error("address moved in cycle");
cov_read: cover property (RSP_VALID);
cov_write: cover property ($fell(WE_N));
cov_sleep: cover property ($rose(IDLE_ASLEEP));
endmodule
bind nfb_ctrl nfb_ctrl_props i_nfb_ctrl_props (.REF_CLK, .RESET, .REQ_READY, .RSP_VALID,
	.IDLE_ASLEEP, .WORD_ADDRESS_IN, .DATA_BUS_OE, .CE_N, .OE_N, .WE_N);

// ---- dv/nfb_flash_model.sv ----
// behavioural flash device, 256 words deep
// assumes writes latch on write-enable rise; data lines have no pull
`timescale 1ns/1ns
module nfb_flash_model #(
	parameter [7:0] ID_CODE   = 8'h5A, // arbitrary value
	parameter [7:0] BUSY_CODE = 8'h3C, // arbitrary status pattern
	parameter int   BUSY_NS   = 1500
) (
	input  wire [17:0] addr,
	input  wire [15:0] din,
	input  wire        ce_n,
	input  wire        oe_n,
	input  wire        we_n,
	output wire [15:0] dout
);
	logic [15:0] mem [0:255];
	logic [1:0]  mode_ff;
	logic        ok;
	logic        busy;
	time         sel_t;
	wire  [15:0] word = busy ? {8'h00, BUSY_CODE} :
		mode_ff == 2'h2 ? {8'h00, ID_CODE} : mem[addr[7:0]];
	// released bus shows the inverse so a stale word never matches
	assign dout = (!ce_n && !oe_n && we_n && ok) ? word : ~word;
	initial begin
		mode_ff = 2'h0;
		busy = 1'b0;
		sel_t = 0;
		foreach (mem[i]) mem[i] = 16'hFFFF;
	end
	// data only a full select access time after each fresh select;
	// a stamp, not a queued update, so a short deselect cannot leak
	always @(negedge ce_n) sel_t = $time;
	always #1 ok = !ce_n && ($time - sel_t >= 90);
	// embedded erase times itself, whatever select does meanwhile
	always @(posedge busy) begin
		#BUSY_NS;
		busy = 1'b0;
	end
	always @(posedge we_n) begin
		if (!ce_n && oe_n && !busy) begin
			if (mode_ff == 2'h1) begin
				mem[addr[7:0]] = din;
				mode_ff = 2'h0;
			end else if (mode_ff == 2'h3) begin
				// model sectors are the upper four bits of its small array
				if (din == 16'h0030) begin
					foreach (mem[i])
						if (i[7:4] == addr[7:4])
							mem[i] = 16'hFFFF;
					busy = 1'b1;
				end
				mode_ff = 2'h0;
			end else begin
				// commands stay in the latch, the array is untouched
				mode_ff = din == 16'h00A0 ? 2'h1 : din == 16'h0090 ? 2'h2 :
					din == 16'h0080 ? 2'h3 : 2'h0;
			end
		end
	end
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the nor flash bus controller
// assumes the behavioural flash model and the bound checker
`timescale 1ns/1ns
`include "nfb_regs.vh"
module tb;
	localparam [7:0]        ID = 8'hC3; // arbitrary value
	localparam [7:0]        BUSY = 8'h3C; // arbitrary status pattern
	logic                   REF_CLK, RESET, REQ_VALID, REQ_READY, RSP_VALID;
	logic                   IDLE_ASLEEP, DATA_BUS_OE, CE_N, OE_N, WE_N;
	logic [1:0]             REQ_OP;
	logic [`NFB_ADDR_W-1:0] REQ_ADDR, WORD_ADDRESS_IN;
	logic [`NFB_DATA_W-1:0] REQ_WDATA, RSP_RDATA, DATA_BUS_I, DATA_BUS_O, flash_q;
	int                     num_errors, comparisons;
	assign DATA_BUS_I = DATA_BUS_OE ? DATA_BUS_O : flash_q;
	nfb_ctrl i_nfb_ctrl (.REF_CLK, .RESET, .REQ_VALID, .REQ_READY, .REQ_OP, .REQ_ADDR,
		.REQ_WDATA, .RSP_VALID, .RSP_RDATA, .IDLE_ASLEEP, .WORD_ADDRESS_IN, .DATA_BUS_I,
		.DATA_BUS_O, .DATA_BUS_OE, .CE_N, .OE_N, .WE_N);
	nfb_flash_model #(.ID_CODE(ID), .BUSY_CODE(BUSY)) i_nfb_flash_model (.addr(WORD_ADDRESS_IN),
		.din(DATA_BUS_I), .ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N), .dout(flash_q));
	////////////////////////////////////////////////////////////////
	task summarize;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task op(input logic [1:0] o, input logic [17:0] a, input logic [15:0] d);
		int n;
		@(posedge REF_CLK);
		REQ_VALID <= 1'b1;
		REQ_OP <= o;
		REQ_ADDR <= a;
		REQ_WDATA <= d;
		n = 0;
		// ready only moves on rising edges, so the falling edge is safe
		do begin @(negedge REF_CLK); n++; end while (REQ_READY !== 1'b1 && n < 200);
		@(posedge REF_CLK);
		REQ_VALID <= 1'b0;
		if (n >= 200) begin num_errors++; summarize; end
	endtask
	task rsp(input logic [15:0] exp);
		int n;
		n = 0;
		do begin @(negedge REF_CLK); n++; end while (RSP_VALID !== 1'b1 && n < 40);
		if (n >= 40) begin num_errors++; summarize; end
		else cmp(RSP_RDATA, exp);
	endtask
	task rd(input logic [17:0] a, input logic [15:0] exp);
		op(`NFB_OP_READ, a, 16'h0000);
		rsp(exp);
	endtask
	////////////////////////////////////////////////////////////////
	task t_boot;
		rd(18'h0_0003, 16'hFFFF);
	endtask
	task t_prog;
		op(`NFB_OP_WRITE, 18'h0_0005, 16'h00A0);
		op(`NFB_OP_WRITE, 18'h0_0005, 16'h1234);
		rd(18'h0_0005, 16'h1234);
		rd(18'h0_0006, 16'hFFFF);
	endtask
	task t_id;
		op(`NFB_OP_WRITE, 18'h0_0000, 16'h0090);
		rd(18'h0_0001, {8'h00, ID});
		op(`NFB_OP_WRITE, 18'h0_0000, 16'h0055);
		rd(18'h0_0005, 16'h1234);
	endtask
	task t_sleep;
		repeat (20) @(negedge REF_CLK);
		cmp({15'h0000, IDLE_ASLEEP}, 16'h0001);
		op(`NFB_OP_READ, 18'h0_0005, 16'h0000);
		@(negedge REF_CLK);
		cmp({15'h0000, IDLE_ASLEEP}, 16'h0000);
		repeat (`NFB_SLEEP_CYC - 1) @(negedge REF_CLK);
		cmp({15'h0000, IDLE_ASLEEP}, 16'h0000);
		rsp(16'h1234);
		cmp({15'h0000, IDLE_ASLEEP}, 16'h0001);
	endtask
	task t_erase;
		op(`NFB_OP_WRITE, 18'h0_0000, 16'h00A0);
		op(`NFB_OP_WRITE, 18'h0_0015, 16'h5678);
		op(`NFB_OP_WRITE, 18'h0_0000, 16'h0080);
		op(`NFB_OP_WRITE, 18'h0_0003, 16'h0030);
		rd(18'h0_0005, {8'h00, BUSY});
		// flash left deselected while the erase runs on
		repeat (250) @(negedge REF_CLK);
		rd(18'h0_0005, 16'hFFFF);
		rd(18'h0_0015, 16'h5678);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	initial begin
		RESET = 1'b1;
		REQ_VALID = 1'b0;
		REQ_OP = 2'h0;
		REQ_ADDR = '0;
		REQ_WDATA = '0;
		num_errors = 0;
		comparisons = 0;
		repeat (10) @(posedge REF_CLK);
		RESET <= 1'b0;
		t_boot;
		t_prog;
		t_id;
		t_sleep;
		t_erase;
		summarize;
	end
endmodule
